// ### omsc_map.svh
// register offsets, field positions and reset values of the mode and system control bank
`ifndef OMSC_MAP_SVH
`define OMSC_MAP_SVH
// ==========================================================
// register offsets (word index on the plain port)
`define OMSC_OFF_MODE_READBACK 4'h0
`define OMSC_OFF_SYSTEM_CONTROL 4'h1
`define OMSC_OFF_PORT_CTRL 4'h2
`define OMSC_OFF_BUS_AREA 4'h3
// ==========================================================
// mode readback fields
`define OMSC_MR_SEL_MSB 11
`define OMSC_MR_SEL_LSB 8
`define OMSC_MR_FIXED_HI 4'h5
`define OMSC_MR_FIXED_MID 4'h5
// ==========================================================
// system control fields
`define OMSC_SC_ACCUMULATE_SATURATION_SELECT 13
`define OMSC_SC_FETCH 11
`define OMSC_SC_ROMEN 10
`define OMSC_SC_EXTERNAL_BUS_ENABLE 9
`define OMSC_SC_ONCHIP_RAM_ENABLE 8
`define OMSC_SC_TRANSFER_CTRL_ADDRESS_MODE 1
`define OMSC_SC_FIXED_ONES 16'hD001
// ==========================================================
// port control fields
`define OMSC_PC_JKE 0
// ==========================================================
// reset values
`define OMSC_RST_ACCUMULATE_SATURATION_SELECT 1'b0
`define OMSC_RST_FETCH 1'b0
`define OMSC_RST_ONCHIP_RAM_ENABLE 1'b1
`define OMSC_RST_TRANSFER_CTRL_ADDRESS_MODE 1'b1
`define OMSC_RST_AREA 8'h00
`endif

// ### omsc_pkg.sv
// types of the mode and system control bank
package omsc_pkg;
   typedef enum logic [2:0] {
      OMSC_MODE_NONE,
      OMSC_MODE_1,
      OMSC_MODE_2,
      OMSC_MODE_3,
      OMSC_MODE_4,
      OMSC_MODE_5,
      OMSC_MODE_6,
      OMSC_MODE_7
   } omsc_mode_t;
   typedef struct packed {
      logic [3:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } omsc_req_t;
   typedef struct packed {
      logic romEnable;
      logic extBusEnable;
      logic bus16;
      logic portDEFAddr;
      logic portIData;
      logic portJKAvail;
      logic flashProg;
      logic scanEnable;
      logic modeInvalid;
   } omsc_pins_t;
endpackage : omsc_pkg

// ### omsc_ctrl.sv
// operating mode decode, mode readback and system control registers
`include "omsc_map.svh"

// ==========================================================
// Notes on behaviour
// - mode pins give modes one to seven
// - rom off in modes four, five
// - modes one to three act as seven
// - mode four starts sixteen bit wide
// - modes five, six start eight bit
// - any sixteen bit area means wide bus while bus enable is set
// - mode six address ports need direction
// - mode seven external space needs enable
// - ports j, k need their enable bit
// - readback read latches mode pins
// - mode select field encodes each mode
// - readback fixed bits, writes ignored
// - bit thirteen selects saturating accumulate
// - bit eleven selects prefetch width
// - bit ten shows rom enable, read-only
// - bus enable fixed or guarded writable
// - ram enable resets to one
// - bit one selects transfer address mode
// - reserved bits read fixed values
// - expansion area external only in modes four to six, when enabled
module omsc_ctrl (
   // clock, reset, enable
   input  wire logic                clk,
   input  wire logic                sys_rst,
   input  wire logic                clkEn,
   // strap pins
   input  wire logic [2:0]          modePins,
   // register port
   input  wire omsc_pkg::omsc_req_t busReq,
   output logic [15:0]              rdData,
   // direction registers of ports d, e, f
   input  wire logic [2:0]          portDirDEF,
   // decoded control
   output omsc_pkg::omsc_pins_t     pinCtrl,
   output logic                     accSaturate,
   output logic                     fetch16,
   output logic                     ramEnable,
   output logic                     xferShortAddr,
   output logic                     expansionExternal
);
   import omsc_pkg::*;

   // ==========================================================
   // mode capture
   omsc_mode_t modeR;
   logic       capturedR;
   logic       inResetR;
   logic [2:0] mdLatchR;
   logic       mdHeldR;

   // pins are caught once after reset release and then held
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         inResetR  <= 1'b1;
         capturedR <= 1'b0;
         modeR     <= OMSC_MODE_NONE;
      end else if (clkEn && inResetR) begin
         inResetR  <= 1'b0;
         capturedR <= 1'b1;
         modeR     <= omsc_mode_t'(modePins);
      end
   end

   logic isExtMode;
   logic isRomOff;
   logic isSingle;
   assign isExtMode = (modeR == OMSC_MODE_4) || (modeR == OMSC_MODE_5) ||
                      (modeR == OMSC_MODE_6);
   assign isRomOff  = (modeR == OMSC_MODE_4) || (modeR == OMSC_MODE_5);
   assign isSingle  = capturedR && !isExtMode && (modeR != OMSC_MODE_NONE);

   // ==========================================================
   // readback latch
   logic rdReadback;
   assign rdReadback = busReq.rd && (busReq.addr == `OMSC_OFF_MODE_READBACK);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mdLatchR <= 3'h0;
         mdHeldR  <= 1'b0;
      end else if (clkEn && rdReadback && !mdHeldR) begin
         mdLatchR <= modePins;
         mdHeldR  <= 1'b1;
      end
   end

   function automatic logic [3:0] selCode(input logic [2:0] m);
      case (m)
         3'h1:    selCode = 4'hD;
         3'h2:    selCode = 4'hC;
         3'h3:    selCode = 4'h4;
         3'h4:    selCode = 4'h2;
         3'h5:    selCode = 4'h1;
         3'h6:    selCode = 4'h5;
         3'h7:    selCode = 4'h4;
         default: selCode = 4'h0;
      endcase
   endfunction

   logic [2:0]  mdShown;
   logic [15:0] readbackVal;
   // before the first read the field follows the pins live
   assign mdShown     = (mdHeldR || rdReadback) ? (mdHeldR ? mdLatchR : modePins) : modePins;
   assign readbackVal = {`OMSC_MR_FIXED_HI, selCode(mdShown), `OMSC_MR_FIXED_MID,
                         selCode(mdShown)};

   // ==========================================================
   // system control, port control and area width registers
   logic macsR;
   logic fetchR;
   logic expeR;
   logic rameR;
   logic dtcR;
   logic jkeR;
   logic [7:0] area16R;
   logic wrSys;
   logic wrPort;
   logic wrArea;
   assign wrSys  = clkEn && busReq.wr && (busReq.addr == `OMSC_OFF_SYSTEM_CONTROL);
   assign wrPort = clkEn && busReq.wr && (busReq.addr == `OMSC_OFF_PORT_CTRL);
   assign wrArea = clkEn && busReq.wr && (busReq.addr == `OMSC_OFF_BUS_AREA);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         macsR  <= `OMSC_RST_ACCUMULATE_SATURATION_SELECT;
         fetchR <= `OMSC_RST_FETCH;
         rameR  <= `OMSC_RST_ONCHIP_RAM_ENABLE;
         dtcR   <= `OMSC_RST_TRANSFER_CTRL_ADDRESS_MODE;
      end else if (wrSys) begin
         macsR  <= busReq.wdata[`OMSC_SC_ACCUMULATE_SATURATION_SELECT];
         fetchR <= busReq.wdata[`OMSC_SC_FETCH];
         rameR  <= busReq.wdata[`OMSC_SC_ONCHIP_RAM_ENABLE];
         dtcR   <= busReq.wdata[`OMSC_SC_TRANSFER_CTRL_ADDRESS_MODE];
      end
   end

   // bus enable: forced in extended modes, guarded by port j/k enable in modes one to three and seven
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         expeR <= 1'b0;
      end else if (clkEn && capturedR && isExtMode) begin
         expeR <= 1'b1;
      end else if (wrSys && isSingle && !jkeR) begin
         expeR <= busReq.wdata[`OMSC_SC_EXTERNAL_BUS_ENABLE];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         jkeR <= 1'b0;
      end else if (wrPort) begin
         jkeR <= busReq.wdata[`OMSC_PC_JKE];
      end
   end

   // bit set marks that area as sixteen bit; mode four starts all wide
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         area16R <= `OMSC_RST_AREA;
      end else if (clkEn && inResetR) begin
         area16R <= (omsc_mode_t'(modePins) == OMSC_MODE_4) ? 8'hFF : 8'h00;
      end else if (wrArea) begin
         area16R <= busReq.wdata[7:0];
      end
   end

   logic [15:0] sysVal;
   always_comb begin
      sysVal                 = `OMSC_SC_FIXED_ONES;
      sysVal[`OMSC_SC_ACCUMULATE_SATURATION_SELECT]  = macsR;
      sysVal[`OMSC_SC_FETCH] = fetchR;
      sysVal[`OMSC_SC_ROMEN] = !isRomOff;
      sysVal[`OMSC_SC_EXTERNAL_BUS_ENABLE]  = expeR;
      sysVal[`OMSC_SC_ONCHIP_RAM_ENABLE]  = rameR;
      sysVal[`OMSC_SC_TRANSFER_CTRL_ADDRESS_MODE] = dtcR;
   end

   // ==========================================================
   // read port: data in the cycle after the strobe, unmapped reads zero
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdData <= 16'h0000;
      end else if (clkEn) begin
         if (busReq.rd) begin
            case (busReq.addr)
               `OMSC_OFF_MODE_READBACK:  rdData <= readbackVal;
               `OMSC_OFF_SYSTEM_CONTROL: rdData <= sysVal;
               `OMSC_OFF_PORT_CTRL:      rdData <= {15'h0000, jkeR};
               `OMSC_OFF_BUS_AREA:       rdData <= {8'h00, area16R};
               default:                  rdData <= 16'h0000;
            endcase
         end else begin
            rdData <= 16'h0000;
         end
      end
   end

   // ==========================================================
   // decoded pin roles and control outputs
   logic wide;
   assign wide = |area16R;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pinCtrl           <= '0;
         accSaturate       <= 1'b0;
         fetch16           <= 1'b0;
         ramEnable         <= 1'b1;
         xferShortAddr     <= 1'b1;
         expansionExternal <= 1'b0;
      end else if (clkEn) begin
         pinCtrl.romEnable    <= !isRomOff;
         pinCtrl.extBusEnable <= expeR;
         pinCtrl.bus16        <= expeR && wide;
         pinCtrl.portDEFAddr  <= isRomOff ? expeR :
                                 (expeR && (&portDirDEF));
         pinCtrl.portIData    <= expeR && wide;
         pinCtrl.portJKAvail  <= isSingle && !expeR && jkeR;
         pinCtrl.flashProg    <= (modeR == OMSC_MODE_1) || (modeR == OMSC_MODE_2);
         pinCtrl.scanEnable   <= (modeR == OMSC_MODE_3);
         pinCtrl.modeInvalid  <= capturedR && (modeR == OMSC_MODE_NONE);
         accSaturate          <= macsR;
         fetch16              <= fetchR;
         ramEnable            <= rameR;
         xferShortAddr        <= dtcR;
         expansionExternal    <= isExtMode && expeR;
      end
   end

   // ==========================================================
   // checks
   a_rom_bit_mode: assert property (@(posedge clk) disable iff (sys_rst)
      busReq.rd && busReq.addr == `OMSC_OFF_SYSTEM_CONTROL && clkEn
      |=> rdData[`OMSC_SC_ROMEN] == !isRomOff)
      else $error("rom bit mismatch");
   a_reserved_bits: assert property (@(posedge clk) disable iff (sys_rst)
      busReq.rd && busReq.addr == `OMSC_OFF_SYSTEM_CONTROL && clkEn
      |=> rdData[15:14] == 2'b11 && rdData[12] && rdData[0] && rdData[7:2] == 6'h00)
      else $error("reserved bits wrong");
   a_readback_fixed: assert property (@(posedge clk) disable iff (sys_rst)
      busReq.rd && busReq.addr == `OMSC_OFF_MODE_READBACK && clkEn
      |=> rdData[15:12] == 4'h5 && rdData[7:4] == 4'h5)
      else $error("readback fixed bits wrong");
   a_latch_hold: assert property (@(posedge clk) disable iff (sys_rst)
      mdHeldR && clkEn |=> mdLatchR == $past(mdLatchR))
      else $error("readback latch moved");
   a_ext_bus_on: assert property (@(posedge clk) disable iff (sys_rst)
      capturedR && isExtMode && clkEn |=> expeR)
      else $error("bus enable not forced");
   a_external_bus_enable_guard: assert property (@(posedge clk) disable iff (sys_rst)
      jkeR && !isExtMode && clkEn |=> $stable(expeR))
      else $error("bus enable changed while guarded");
   a_jk_avail: assert property (@(posedge clk) disable iff (sys_rst)
      clkEn && $past(clkEn) && pinCtrl.portJKAvail |-> $past(jkeR) && !$past(expeR))
      else $error("ports j k available wrongly");
   a_wide_bus: assert property (@(posedge clk) disable iff (sys_rst)
      clkEn && expeR && area16R != 8'h00 |=> pinCtrl.bus16 || !clkEn)
      else $error("bus not wide");
   c_mode4: cover property (@(posedge clk) capturedR && modeR == OMSC_MODE_4);
   c_mode7_external_bus_enable: cover property (@(posedge clk) isSingle && expeR);
   c_readback: cover property (@(posedge clk) rdReadback ##1 mdHeldR);
   c_jk: cover property (@(posedge clk) pinCtrl.portJKAvail);
endmodule // omsc_ctrl

// ### omsc_strap_model.sv
// board strapping model for the mode select pins
module omsc_strap_model (
   // strap code chosen by the bench
   input  wire logic [2:0] strapCode,
   // levels seen by the device
   output logic [2:0]      modePins
);
   // ==========================================================
   // straps
   // plain resistors: the level only moves when the bench re-straps the board
   assign modePins = strapCode;
endmodule // omsc_strap_model

// ### operating_mode_system_control_tb_top.sv
// self-checking bench for the mode and system control bank
`include "omsc_map.svh"
module operating_mode_system_control_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import omsc_pkg::*;
   // ==========================================================
   // signals and model state
   logic        clk;
   logic        sys_rst;
   logic        clkEn;
   logic [2:0]  strapCode;
   logic [2:0]  modePins;
   logic [2:0]  portDirDEF;
   omsc_req_t   busReq;
   logic [15:0] rdData;
   omsc_pins_t  pinCtrl;
   logic        accSaturate;
   logic        fetch16;
   logic        ramEnable;
   logic        xferShortAddr;
   logic        expansionExternal;
   int          miscompares;
   int          checks;
   int          mode;
   logic [31:0] seed;
   logic [31:0] rnd;
   logic [15:0] rv;
   logic [15:0] sc;
   logic [15:0] exp16;
   logic [7:0]  area;
   logic        jke;
   logic [3:0]  codeTab [8] = '{4'h0, 4'hD, 4'hC, 4'h4, 4'h2, 4'h1, 4'h5, 4'h4};

   omsc_strap_model STRAP (.strapCode(strapCode), .modePins(modePins));
   omsc_ctrl DUT (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn), .modePins(modePins),
      .busReq(busReq), .rdData(rdData), .portDirDEF(portDirDEF), .pinCtrl(pinCtrl),
      .accSaturate(accSaturate), .fetch16(fetch16), .ramEnable(ramEnable),
      .xferShortAddr(xferShortAddr), .expansionExternal(expansionExternal));

   always #10 clk = ~clk;

   // ==========================================================
   // tasks
   task automatic chk(input logic [15:0] seen, input logic [15:0] want);
      checks++;
      if (seen !== want) begin
         miscompares++;
         $display("FAIL t=%0t seen %h want %h", $time, seen, want);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      busReq.wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      busReq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      busReq.rd <= 1'b0;
      #1 d = rdData;
   endtask
   // model of a system control write: only bits 13, 11, 8, 1 and a guarded bit 9 move
   task automatic wsc(input logic [15:0] d);
      wr(`OMSC_OFF_SYSTEM_CONTROL, d);
      sc = (sc & 16'h0600) | (d & 16'h2902) | 16'hD001;
      if (mode inside {1, 2, 3, 7} && !jke)
         sc[9] = d[9];
   endtask
   task automatic boot(input int m);
      @(posedge clk);
      strapCode <= m[2:0];
      portDirDEF <= 3'b000;
      sys_rst <= 1'b1;
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (3) @(posedge clk);
      mode = m;
      jke = 1'b0;
      area = (m == 4) ? 8'hFF : 8'h00;
      sc = 16'hD103 | ((m inside {4, 5}) ? 16'h0000 : 16'h0400);
      sc = sc | ((m inside {4, 5, 6}) ? 16'h0200 : 16'h0000);
   endtask
   task automatic outs();
      repeat (2) @(posedge clk);
      #1;
      chk({5'h00, accSaturate, fetch16, ramEnable, xferShortAddr, pinCtrl.extBusEnable,
         expansionExternal, pinCtrl.romEnable, pinCtrl.flashProg, pinCtrl.scanEnable,
         pinCtrl.modeInvalid, pinCtrl.portJKAvail, pinCtrl.portDEFAddr},
         {5'h00, sc[13], sc[11], sc[8], sc[1], sc[9], sc[9] & (mode inside {4, 5, 6}),
         !(mode inside {4, 5}),
         (mode inside {1, 2}), (mode == 3), (mode == 0),
         (mode inside {1, 2, 3, 7}) & !sc[9] & jke,
         (mode inside {4, 5}) | (sc[9] & (&portDirDEF))});
      rd(`OMSC_OFF_SYSTEM_CONTROL, rv);
      chk(rv, sc);
   endtask
   task automatic busChk();
      repeat (2) @(posedge clk);
      #1 chk({14'h0000, pinCtrl.bus16, pinCtrl.portIData}, {14'h0000, |area, |area});
   endtask

   // ==========================================================
   // main sequence
   initial begin
      clk = 1'b0;
      sys_rst = 1'b1;
      clkEn = 1'b1;
      strapCode = 3'b111;
      portDirDEF = 3'b000;
      busReq = '0;
      miscompares = 0;
      checks = 0;
      seed = 32'h96b0_7f70;
      for (int m = 0; m < 8; m++) begin
         boot(m);
         outs();
         repeat (3) begin
            rnd = $random(seed);
            // reserved bits always written with their documented values
            wsc((rnd[15:0] & 16'h2B02) | 16'hD001);
            outs();
         end
         // with j/k enabled software rewrites the bus enable bit unchanged only
         wr(`OMSC_OFF_PORT_CTRL, 16'h0001);
         jke = 1'b1;
         wsc(16'hFD03 | {6'h00, sc[9], 9'h000});
         outs();
         wr(`OMSC_OFF_PORT_CTRL, 16'h0000);
         jke = 1'b0;
         wsc(16'hFF03);
         @(posedge clk);
         portDirDEF <= 3'b011;
         outs();
         @(posedge clk);
         portDirDEF <= 3'b111;
         outs();
         if (m inside {4, 5, 6}) begin
            busChk();
            wr(`OMSC_OFF_BUS_AREA, 16'h0000);
            area = 8'h00;
            busChk();
            wr(`OMSC_OFF_BUS_AREA, 16'h0004);
            area = 8'h04;
            busChk();
         end
         rd(4'hF, rv);
         chk(rv, 16'h0000);
         if (m > 0) begin
            exp16 = {4'h5, codeTab[m], 4'h5, codeTab[m]};
            rd(`OMSC_OFF_MODE_READBACK, rv);
            chk(rv, exp16);
            @(posedge clk);
            #1 chk(rdData, 16'h0000);
            // re-strap after the latching read; only the readback is looked at now
            strapCode <= m[2:0] ^ 3'b011;
            wr(`OMSC_OFF_MODE_READBACK, 16'hFFFF);
            rd(`OMSC_OFF_MODE_READBACK, rv);
            chk(rv, exp16);
         end
      end
      print_verdict();
   end

   // ==========================================================
   // watchdog
   initial begin
      repeat (8000) @(posedge clk);
      miscompares++;
      print_verdict();
   end
endmodule // operating_mode_system_control_tb_top
